/* File: hw/i2c_pkg.sv */
package i2c_pkg;

  // ----------------------------------------------------------------
  // Register addresses in the special function register space.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'hDA;  // Serial data.
  localparam logic [7:0] ADDR_OWN  = 8'hDB;  // Own slave address.
  localparam logic [7:0] ADDR_CTRL = 8'hDC;  // Serial control.
  localparam logic [7:0] ADDR_STAT = 8'hDD;  // Serial state code.

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int CTL_CR2 = 7;  // Clock rate select, top bit.
  localparam int CTL_ENS = 6;  // Module enable.
  localparam int CTL_STA = 5;  // Start request.
  localparam int CTL_STO = 4;  // Stop request.
  localparam int CTL_SI  = 3;  // Serial interrupt flag.
  localparam int CTL_AA  = 2;  // Acknowledge control.
  localparam int CTL_CR1 = 1;  // Clock rate select, middle bit.
  localparam int CTL_CR0 = 0;  // Clock rate select, low bit.
  localparam int OWN_GC  = 0;  // General call accept.

  // ----------------------------------------------------------------
  // Values after reset.
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_RST = 8'h00;  // Serial data.
  localparam logic [7:0] OWN_RST  = 8'h00;  // Own slave address.
  localparam logic [7:0] CODE_RST = 8'hF8;  // State 11111, timeout 000.

  // ----------------------------------------------------------------
  // Protocol state codes.
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_START  = 8'h08;  // Start sent.
  localparam logic [7:0] ST_RSTART = 8'h10;  // Repeated start sent.
  localparam logic [7:0] ST_AW_ACK = 8'h18;  // Write address acknowledged.
  localparam logic [7:0] ST_AW_NAK = 8'h20;  // Write address refused.
  localparam logic [7:0] ST_DT_ACK = 8'h28;  // Data sent, acknowledged.
  localparam logic [7:0] ST_DT_NAK = 8'h30;  // Data sent, refused.
  localparam logic [7:0] ST_AR_ACK = 8'h40;  // Read address acknowledged.
  localparam logic [7:0] ST_AR_NAK = 8'h48;  // Read address refused.
  localparam logic [7:0] ST_DR_ACK = 8'h50;  // Data received, ack sent.
  localparam logic [7:0] ST_DR_NAK = 8'h58;  // Data received, nack sent.
  localparam logic [7:0] ST_NONE   = 8'hF8;  // No relevant state.

  // ----------------------------------------------------------------
  // Bit timing: prescalers per rate code, four phases per bit.
  // ----------------------------------------------------------------
  localparam logic [9:0] PRESCALE [0:7] = '{10'h100, 10'h0E0, 10'h0C0,
    10'h0A0, 10'h3C0, 10'h078, 10'h03C, 10'h010};  // Last entry unused.
  localparam logic [2:0] CR_TIMER  = 3'h7;  // Rate code using timer 1.
  localparam int         FIFO_W    = 8;     // Transmit queue width.
  localparam int         FIFO_D    = 16;    // Transmit queue depth.

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,  // Bus released, waiting for a start request.
    S_START = 3'b001,  // Making a start or repeated start.
    S_SHIFT = 3'b010,  // Moving eight bits and the acknowledge bit.
    S_HOLD  = 3'b011,  // Clock held low until the flag is cleared.
    S_STOP  = 3'b100   // Making a stop.
  } fsm_t;

  typedef struct packed {
    logic [7:0] addr;   // Register address.
    logic       wr;     // Write strobe, one cycle.
    logic       rd;     // Read strobe, one cycle.
    logic [7:0] wdata;  // Write data.
  } sfr_req_t;

  typedef struct packed {
    logic scl;  // Clock line level.
    logic sda;  // Data line level.
  } bus_pins_t;

endpackage : i2c_pkg

/* File: hw/i2c_master_slave_core_regs.sv */
// How it works
// [R1] Data register holds byte; no access while shifting. Code blocks only writes; reads still answer.
// [R2] Software reads data only after flag raised.
// [R3] Own address in 7:1, bit 0 general call.
// [R4] Rate code divides clock or uses timer.
// [R5] Enable clear halts engine, hides registers.
// [R6] Start request makes START once bus free.
// [R7] Stop request in master mode makes STOP.
// [R8] Entering any state but F8h raises flag.
// [R9] Flag cleared only by writing zero.
// [R10] Received byte answered by acknowledge control.
// [R11] State code in 7:3, timeout bits zero.
// [R12] After START, load address, clear flag, send.
// [R13] After repeated START, any address is sent.
// [R14] Address acked: data, restart or stop.
// [R15] Address refused: same three choices. After 48h the code offers only restart or stop.
// [R16] Start and stop together: STOP then START.
// [R17] Software enables module before other setup.
// [R18] Data acked: next byte, restart or stop.
// [R19] Flag set holds clock low, engine waits.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Queue of bytes between the data register and the shifter.
// ------------------------------------------------------------------
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Storage and pointers with one wrap bit each.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fifo_state_t;

  fifo_state_t cur;  // Registered state.
  fifo_state_t nxt;  // Next state.

  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = !((cur.wp[AW] != cur.rp[AW]) && (cur.wp[AW-1:0] == cur.rp[AW-1:0]));
  assign out_valid = (cur.wp != cur.rp);
  assign out_data  = cur.mem[cur.rp[AW-1:0]];

  // Push, pop and flush.
  always_comb begin
    nxt = cur;
    if (in_valid && in_ready) begin
      nxt.mem[cur.wp[AW-1:0]] = in_data;
      nxt.wp = cur.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      nxt.rp = cur.rp + 1'b1;
    end
    if (flush) begin
      nxt.rp = cur.wp;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end
endmodule : sync_fifo

// ------------------------------------------------------------------
// Two-wire controller with its register file.
// ------------------------------------------------------------------
module i2c_master_slave_core_regs
  import i2c_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst_n,
  input  wire sfr_req_t  sfr_req,
  output logic [7:0]     sfr_rdata,
  input  wire logic      t1_overflow,
  input  wire bus_pins_t bus_in,
  output logic           scl_out,
  output logic           scl_oe,
  output logic           sda_out,
  output logic           sda_oe
);

  // All registered state of the controller except the byte queue.
  typedef struct packed {
    logic [7:0] data;     // Serial data register.
    logic [7:0] own;      // Own slave address register.
    logic [2:0] cr;       // Clock rate select.
    logic       ens;      // Module enable.
    logic       start_request;      // Start request.
    logic       stop_request;      // Stop request.
    logic       si;       // Serial interrupt flag.
    logic       aa;       // Acknowledge control.
    logic [7:0] code;     // Protocol state code.
    fsm_t       fsm;      // Engine state.
    logic [1:0] phase;    // Quarter of the current bit.
    logic [3:0] bitn;     // Bit number, 8 is the acknowledge bit.
    logic [7:0] shreg;    // Shift register.
    logic       tx;       // Shifting out rather than in.
    logic       is_addr;  // Current byte is an address.
    logic       rw;       // Bit 0 of the last byte sent, direction if an address.
    logic       ack;      // Acknowledge seen or given.
    logic       mst;      // This device owns the bus.
    logic       busy;     // Bus is between a start and a stop.
    logic       sda_q;    // Data line one cycle ago.
    logic [9:0] div;      // Quarter period counter.
    logic       ovf;      // Timer overflow pair counter.
    logic       scl_oe;   // Pulling the clock line low.
    logic       sda_oe;   // Pulling the data line low.
    logic       pin_lvl;  // Level driven while enabled, always low.
    logic [7:0] rdata;    // Read data.
  } core_t;

  core_t      cur;        // Registered state.
  core_t      nxt;        // Next state.
  logic       tick;       // One quarter bit has elapsed.
  logic       advance;    // Move to the next quarter.
  logic       push;       // Byte offered to the queue.
  logic       push_rdy;   // Queue has room.
  logic       pop;        // Shifter takes a byte.
  logic       q_valid;    // Queue holds a byte.
  logic [7:0] q_data;     // Oldest queued byte.
  logic [9:0] qtr;        // Quarter period in clock cycles.
  logic       tx_state;   // Code after which a byte is sent.

  assign sfr_rdata = cur.rdata;
  assign scl_out   = cur.pin_lvl;
  assign sda_out   = cur.pin_lvl;
  assign scl_oe    = cur.scl_oe;
  assign sda_oe    = cur.sda_oe;

  // Quarter period for the selected prescaler.
  assign qtr = PRESCALE[cur.cr] >> 2;  // see [R4]

  // Codes after which the next action is sending a byte.
  assign tx_state = (cur.code == ST_START) || (cur.code == ST_RSTART) ||
                    (cur.code == ST_AW_ACK) || (cur.code == ST_AW_NAK) ||
                    (cur.code == ST_DT_ACK) || (cur.code == ST_DT_NAK);

  // Bytes wait here until the engine is ready for them.
  sync_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_txq (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (!cur.ens),
    .in_valid  (push),
    .in_ready  (push_rdy),
    .in_data   (sfr_req.wdata),
    .out_valid (q_valid),
    .out_ready (pop),
    .out_data  (q_data)
  );

  // ----------------------------------------------------------------
  // Next state: register access, bit timing and the bus engine.
  // ----------------------------------------------------------------
  always_comb begin
    nxt     = cur;
    tick    = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    advance = 1'b0;

    // Register reads answer on the next cycle.
    if (sfr_req.rd) begin
      nxt.rdata = 8'h00;
      if (sfr_req.addr == ADDR_CTRL) begin
        nxt.rdata = {cur.cr[2], cur.ens, cur.start_request, cur.stop_request,
                     cur.si, cur.aa, cur.cr[1], cur.cr[0]};
      end else if (cur.ens) begin  // see [R5]
        unique case (sfr_req.addr)
          ADDR_DATA: nxt.rdata = cur.data;  // see [R1]
          ADDR_OWN:  nxt.rdata = cur.own;  // see [R3]
          ADDR_STAT: nxt.rdata = {cur.code[7:3], 3'h0};  // see [R11]
          default:   nxt.rdata = 8'h00;
        endcase
      end
    end

    // Register writes; the control register stays reachable.
    if (sfr_req.wr) begin
      if (sfr_req.addr == ADDR_CTRL) begin
        nxt.cr  = {sfr_req.wdata[CTL_CR2], sfr_req.wdata[CTL_CR1],
                   sfr_req.wdata[CTL_CR0]};  // see [R4]
        nxt.ens = sfr_req.wdata[CTL_ENS];  // see [R5]
        nxt.start_request = sfr_req.wdata[CTL_STA];  // see [R6]
        nxt.stop_request = sfr_req.wdata[CTL_STO];  // see [R7]
        nxt.aa  = sfr_req.wdata[CTL_AA];  // see [R10]
        // Only a zero written to the flag changes it.
        if (!sfr_req.wdata[CTL_SI]) begin
          nxt.si = 1'b0;  // see [R9]
        end
      end else if (cur.ens && sfr_req.addr == ADDR_OWN) begin
        nxt.own = sfr_req.wdata;  // see [R3]
      end else if (cur.ens && sfr_req.addr == ADDR_DATA && cur.fsm != S_SHIFT) begin
        push = 1'b1;  // see [R1]
        if (push_rdy) begin
          nxt.data = sfr_req.wdata;
        end
      end
    end

    // Watch the bus for other masters' start and stop conditions.
    nxt.sda_q = bus_in.sda;
    if (bus_in.scl && cur.sda_q && !bus_in.sda) begin
      nxt.busy = 1'b1;
    end else if (bus_in.scl && !cur.sda_q && bus_in.sda) begin
      nxt.busy = 1'b0;
    end

    // Quarter bit tick from the prescaler or from timer overflows.
    if (cur.cr == CR_TIMER) begin
      if (t1_overflow) begin
        nxt.ovf = !cur.ovf;
        tick    = cur.ovf;  // see [R4]
      end
    end else if (cur.div >= qtr - 10'h001) begin
      nxt.div = 10'h000;
      tick    = 1'b1;  // see [R4]
    end else begin
      nxt.div = cur.div + 10'h001;
    end

    // A released clock held low by another device stretches the bit.
    advance = tick && !(cur.phase == 2'h2 && !bus_in.scl && !cur.scl_oe);
    if (advance) begin
      nxt.phase = cur.phase + 2'h1;
    end

    unique case (cur.fsm)
      // Released bus; a start waits for the bus to be free.
      S_IDLE: begin
        nxt.scl_oe = 1'b0;
        nxt.sda_oe = 1'b0;
        nxt.mst    = 1'b0;
        if (cur.start_request && !cur.busy) begin  // see [R6]
          nxt.fsm   = S_START;
          nxt.phase = 2'h0;
        end
      end

      // Release data, release clock, pull data, pull clock.
      S_START: begin
        if (advance) begin
          unique case (cur.phase)
            2'h0: nxt.scl_oe = 1'b0;
            2'h1: nxt.sda_oe = 1'b1;
            2'h2: nxt.scl_oe = 1'b1;
            2'h3: begin
              nxt.code = cur.mst ? ST_RSTART : ST_START;  // see [R13]
              nxt.mst  = 1'b1;
              nxt.si   = 1'b1;  // see [R8]
              nxt.fsm  = S_HOLD;
            end
          endcase
        end
      end

      // Eight data bits then the acknowledge bit.
      S_SHIFT: begin
        if (advance) begin
          unique case (cur.phase)
            2'h0: nxt.scl_oe = 1'b1;
            2'h1: nxt.scl_oe = 1'b0;
            2'h2: begin
              if (cur.bitn == 4'h8) begin
                nxt.ack = cur.tx ? !bus_in.sda : cur.aa;
              end else if (!cur.tx) begin
                nxt.shreg = {cur.shreg[6:0], bus_in.sda};
              end
            end
            2'h3: begin
              nxt.scl_oe = 1'b1;
              if (cur.bitn == 4'h8) begin
                nxt.si  = 1'b1;  // see [R8]
                nxt.fsm = S_HOLD;
                if (cur.is_addr) begin
                  nxt.tx = !cur.rw;
                  if (cur.rw) begin
                    nxt.code = cur.ack ? ST_AR_ACK : ST_AR_NAK;  // see [R12]
                  end else begin
                    nxt.code = cur.ack ? ST_AW_ACK : ST_AW_NAK;  // see [R13]
                  end
                end else if (cur.tx) begin
                  nxt.code = cur.ack ? ST_DT_ACK : ST_DT_NAK;  // see [R18]
                end else begin
                  nxt.data = cur.shreg;
                  nxt.code = cur.ack ? ST_DR_ACK : ST_DR_NAK;  // see [R10]
                end
              end else begin
                nxt.bitn = cur.bitn + 4'h1;
                if (cur.tx) begin
                  nxt.shreg = {cur.shreg[6:0], 1'b0};
                end
                if (cur.bitn == 4'h7) begin
                  nxt.sda_oe = cur.tx ? 1'b0 : cur.aa;  // see [R10]
                end else begin
                  nxt.sda_oe = cur.tx ? !cur.shreg[6] : 1'b0;
                end
              end
            end
          endcase
        end
      end

      // Clock held low until software clears the flag.
      S_HOLD: begin
        nxt.scl_oe = 1'b1;  // see [R19]
        nxt.phase  = 2'h0;
        nxt.bitn   = 4'h0;
        if (!cur.si) begin
          if (cur.stop_request) begin
            nxt.fsm    = S_STOP;  // see [R7]
            nxt.sda_oe = 1'b1;
          end else if (cur.start_request) begin
            nxt.fsm    = S_START;  // see [R14]
            nxt.sda_oe = 1'b0;
          end else if (tx_state && q_valid) begin
            pop         = 1'b1;  // see [R15]
            nxt.shreg   = q_data;
            nxt.tx      = 1'b1;
            nxt.is_addr = (cur.code == ST_START) || (cur.code == ST_RSTART);  // see [R12]
            nxt.rw      = q_data[0];
            nxt.sda_oe  = !q_data[7];
            nxt.fsm     = S_SHIFT;
          end else if (cur.code == ST_AR_ACK || cur.code == ST_DR_ACK) begin
            nxt.tx      = 1'b0;
            nxt.is_addr = 1'b0;
            nxt.sda_oe  = 1'b0;
            nxt.fsm     = S_SHIFT;
          end
        end
      end

      // Pull data, release clock, release data, then finish.
      S_STOP: begin
        if (advance) begin
          unique case (cur.phase)
            2'h0: nxt.scl_oe = 1'b0;
            2'h1: nxt.sda_oe = 1'b0;
            2'h2: nxt.sda_oe = 1'b0;
            2'h3: begin
              nxt.stop_request  = 1'b0;  // see [R16]
              nxt.code = ST_NONE;  // see [R8]
              nxt.mst  = 1'b0;
              nxt.fsm  = S_IDLE;
            end
          endcase
        end
      end

      default: nxt.fsm = S_IDLE;
    endcase

    // A disabled block is idle with the bus released.
    if (!cur.ens) begin
      nxt.fsm    = S_IDLE;  // see [R5]
      nxt.scl_oe = 1'b0;
      nxt.sda_oe = 1'b0;
      nxt.div    = 10'h000;
      pop        = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur      <= '0;
      cur.data <= DATA_RST;
      cur.own  <= OWN_RST;
      cur.code <= CODE_RST;  // see [R11]
    end else begin
      cur <= nxt;
    end
  end

endmodule : i2c_master_slave_core_regs

/* File: tb/i2c_core_monitor.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checker for the two-wire controller.
// ------------------------------------------------------------
module i2c_core_monitor
  import i2c_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire sfr_req_t   sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic       t1_overflow,
  input wire bus_pins_t  bus_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe
);
  logic ens_ff;  // Last written module enable.
  logic sta_ff;  // Last written start request.
  logic sto_ff;  // Last written stop request.

  // Shadow the control bits as software last wrote them.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ens_ff <= 1'b0;
      sta_ff <= 1'b0;
      sto_ff <= 1'b0;
    end else if (sfr_req.wr && sfr_req.addr == ADDR_CTRL) begin
      ens_ff <= sfr_req.wdata[CTL_ENS];
      sta_ff <= sfr_req.wdata[CTL_STA];
      sto_ff <= sfr_req.wdata[CTL_STO];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // A start pulls data low while the clock line is high; a stop releases it.
  sequence start_s; $rose(sda_oe) && bus_in.scl && !scl_oe; endsequence
  sequence stop_s; $fell(sda_oe) && bus_in.scl && !scl_oe; endsequence
  sequence own_wr_s; sfr_req.wr && sfr_req.addr == ADDR_OWN && ens_ff; endsequence
  sequence own_rd_s; sfr_req.rd && sfr_req.addr == ADDR_OWN; endsequence

  own_echo_a:
    assert property (own_wr_s ##2 own_rd_s |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("own address read back differs");
  hidden_read_a:
    assert property (sfr_req.rd && !ens_ff && sfr_req.addr != ADDR_CTRL |=> sfr_rdata == 8'h00)
    else $error("register visible while disabled");
  disabled_quiet_a:
    assert property (!ens_ff && !$past(ens_ff) && !$past(ens_ff, 2) |-> !scl_oe && !sda_oe)
    else $error("bus driven while disabled");
  status_low_a:
    assert property (sfr_req.rd && sfr_req.addr == ADDR_STAT |=> sfr_rdata[2:0] == 3'h0)
    else $error("timeout bits not zero");
  start_gate_a:
    assert property (start_s |-> sta_ff)
    else $error("start without request");
  stop_gate_a:
    assert property (stop_s |-> sto_ff)
    else $error("stop without request");
  read_hold_a:
    assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  drive_low_a:
    assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
endmodule : i2c_core_monitor

bind i2c_master_slave_core_regs i2c_core_monitor mon_u (
  .clock(clock), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .t1_overflow(t1_overflow), .bus_in(bus_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe)
);

/* File: tb/i2c_slave_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Slave on the wire: acks its address, sends a byte when read.
// ------------------------------------------------------------
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] TX   = 8'h96
) (
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sda_oe,
  output logic [7:0] last_rx
);
  logic [7:0] sh;   // Shift of sampled bits.
  logic       act;  // Inside a frame.
  logic       hit;  // Address matched.
  logic       rdm;  // Master reads from us.
  int         cnt;  // Bits seen in this byte.
  int         idx;  // Bytes seen in this frame.

  initial begin
    sda_oe = 1'b0;
    act = 1'b0;
  end

  // Start and stop are data edges while the clock line is high.
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    cnt = 0;
    idx = 0;
    hit = 1'b0;
    rdm = 1'b0;
  end
  always @(posedge sda) if (scl) act = 1'b0;

  // Sample each bit while the clock is high.
  always @(posedge scl) if (act) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end

  // Change our data only while the clock is low.
  always @(negedge scl) begin
    if (act && cnt == 8 && idx == 0) begin
      hit = (sh[7:1] == ADDR);
      rdm = sh[0];
    end
    if (act && cnt == 8) last_rx = sh;
    if (act && cnt == 9) begin
      cnt = 0;
      idx = idx + 1;
    end
    if (act && cnt == 8) sda_oe <= hit && !(rdm && idx > 0);
    else if (act && hit && rdm && idx > 0 && cnt < 8) sda_oe <= !TX[7 - cnt];
    else sda_oe <= 1'b0;
  end
endmodule : i2c_slave_model

/* File: tb/test_i2c_master_slave_core_regs.sv */
`timescale 1ns/1ps

module test_i2c_master_slave_core_regs
  import i2c_pkg::*;
;
  localparam logic [6:0] SLV   = 7'h2A;  // Model address.
  localparam int         LIMIT = 40000;  // Cycle ceiling.
  typedef struct packed {
    logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;
  } row_t;
  logic       clock, rst_n, t1_overflow, scl_oe, sda_oe, s_sda_oe;
  logic [7:0] rdata, got, last_rx;
  sfr_req_t   req;
  bus_pins_t  pins;
  int         fails, total_checks, cyc;
  row_t       rows [0:12];

  // Open-drain wires with pull-ups.
  assign pins = '{scl: !scl_oe, sda: !(sda_oe || s_sda_oe)};

  i2c_master_slave_core_regs dut_u (.clock(clock), .rst_n(rst_n), .sfr_req(req),
    .sfr_rdata(rdata), .t1_overflow(t1_overflow), .bus_in(pins), .scl_out(),
    .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe));
  i2c_slave_model #(.ADDR(SLV)) s_u (.scl(pins.scl), .sda(pins.sda),
    .sda_oe(s_sda_oe), .last_rx(last_rx));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Timer pulses and the hang guard.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    t1_overflow <= (cyc[2:0] == 3'h0);
    if (cyc == LIMIT) begin
      fails = fails + 1;
      test_done();
    end
  end

  // ------------------------------------------------------------
  // Bus tasks.
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      fails = fails + 1;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    q = rdata;
  endtask : rd
  // Poll the flag under a bound, then check the state code.
  task automatic wait_si(input logic [7:0] code);
    int n;
    n = 0;
    rd(ADDR_CTRL, got);
    while (got[CTL_SI] !== 1'b1 && n < 600) begin
      rd(ADDR_CTRL, got);
      n = n + 1;
    end
    rd(ADDR_STAT, got);
    chk(got, code);
  endtask : wait_si
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    req = '0;
    rst_n = 1'b0;
    t1_overflow = 1'b0;
    cyc = 0;
    fails = 0;
    total_checks = 0;
    rows = '{'{1'b0, ADDR_STAT, 8'h00, 8'h00}, '{1'b1, ADDR_CTRL, 8'h40, 8'h00},
      '{1'b0, ADDR_STAT, 8'h00, CODE_RST}, '{1'b0, ADDR_DATA, 8'h00, DATA_RST},
      '{1'b0, ADDR_OWN, 8'h00, OWN_RST}, '{1'b0, ADDR_CTRL, 8'h00, 8'h40},
      '{1'b1, ADDR_OWN, 8'h55, 8'h00}, '{1'b0, ADDR_OWN, 8'h00, 8'h55},
      '{1'b1, ADDR_DATA, 8'hA5, 8'h00}, '{1'b0, ADDR_DATA, 8'h00, 8'hA5},
      '{1'b0, 8'hDE, 8'h00, 8'h00}, '{1'b1, ADDR_CTRL, 8'h00, 8'h00},
      '{1'b0, ADDR_OWN, 8'h00, 8'h00}};
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    // Register table: reset values, access, hidden while disabled.
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wdata);
      end else begin
        rd(rows[i].addr, got);
        chk(got, rows[i].exp);
      end
    end
    $display("test register table done");
    // Write transfer, held flag, start plus stop, restart, refusal, read.
    wr(ADDR_CTRL, 8'hC2);
    wr(ADDR_CTRL, 8'hE2);
    wait_si(ST_START);
    wr(ADDR_CTRL, 8'hCA);
    repeat (100) @(posedge clock);
    rd(ADDR_CTRL, got);
    chk(got, 8'hCA);
    chk({7'h00, scl_oe}, 8'h01);
    wr(ADDR_DATA, {SLV, 1'b0});
    wr(ADDR_CTRL, 8'hC2);
    wait_si(ST_AW_ACK);
    wr(ADDR_DATA, 8'h3C);
    wr(ADDR_CTRL, 8'hC2);
    wait_si(ST_DT_ACK);
    chk(last_rx, 8'h3C);
    wr(ADDR_CTRL, 8'hF2);
    wait_si(ST_START);
    rd(ADDR_CTRL, got);
    chk(got, 8'hEA);
    wr(ADDR_DATA, {SLV, 1'b0});
    wr(ADDR_CTRL, 8'hC2);
    wait_si(ST_AW_ACK);
    wr(ADDR_CTRL, 8'hE2);
    wait_si(ST_RSTART);
    wr(ADDR_DATA, 8'h22);
    wr(ADDR_CTRL, 8'hC2);
    wait_si(ST_AW_NAK);
    wr(ADDR_CTRL, 8'hE2);
    wait_si(ST_RSTART);
    wr(ADDR_DATA, {SLV, 1'b1});
    wr(ADDR_CTRL, 8'hC2);
    wait_si(ST_AR_ACK);
    wr(ADDR_CTRL, 8'hC2);
    wait_si(ST_DR_NAK);
    rd(ADDR_DATA, got);
    chk(got, 8'h96);
    wr(ADDR_CTRL, 8'hD2);
    for (int n = 0; n < 100 && got !== 8'hC2; n++) rd(ADDR_CTRL, got);
    chk(got, 8'hC2);
    rd(ADDR_STAT, got);
    chk(got, ST_NONE);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    // Timer paced rate code: a start and a stop still complete.
    wr(ADDR_CTRL, 8'hE3);
    wait_si(ST_START);
    wr(ADDR_CTRL, 8'hD3);
    for (int n = 0; n < 100 && got !== 8'hC3; n++) rd(ADDR_CTRL, got);
    chk(got, 8'hC3);
    $display("test bus sequence done");
    test_done();
  end
endmodule : test_i2c_master_slave_core_regs
